// [common/timer_mode_defs.vh]
// Register offsets, field positions and encodings of the timer mode and control block.
`ifndef TIMER_MODE_DEFS_VH
`define TIMER_MODE_DEFS_VH

// ==========================================================================
// Register byte offsets
`define OFS_WIDTH_CONFIG   12'h000
`define OFS_HALF_A_MODE    12'h004
`define OFS_HALF_B_MODE    12'h008
`define OFS_TIMER_CONTROL  12'h00C
`define OFS_TIMER_STATUS   12'h010

// ==========================================================================
// Width configuration encodings
`define CFG_CONCAT32       3'h0
`define CFG_CLOCK32        3'h1
`define CFG_SPLIT_BIT      2

// ==========================================================================
// Mode register fields
`define MODE_SEL_LSB       0
`define MODE_SEL_MSB       1
`define MODE_CAPKIND_BIT   2
`define MODE_ALT_BIT       3
`define MODE_WRITE_MASK    32'h0000000F
`define MODE_ONE_SHOT      2'h1
`define MODE_PERIODIC      2'h2
`define MODE_CAPTURE       2'h3

// ==========================================================================
// Control register fields
`define CTL_A_ENABLE       0
`define CTL_A_FREEZE       1
`define CTL_A_EDGE_LSB     2
`define CTL_A_EDGE_MSB     3
`define CTL_CLOCK_EN       4
`define CTL_A_ADC_TRIG     5
`define CTL_A_PWM_INV      6
`define CTL_B_ENABLE       8
`define CTL_B_FREEZE       9
`define CTL_B_EDGE_LSB     10
`define CTL_B_EDGE_MSB     11
`define CTL_WRITE_MASK     32'h00000F7F
`define CFG_WRITE_MASK     32'h00000007

// ==========================================================================
// Edge selection encodings
`define EDGE_RISING        2'h0
`define EDGE_FALLING       2'h1
`define EDGE_BOTH          2'h3

`endif

// [design/edge_select.v]
// Capture edge detector for one timer half.
`timescale 1ns/10ps
`include "timer_mode_defs.vh"

module edge_select (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       pin_sync,
    input  wire [1:0] edge_sel,
    input  wire       armed,
    output reg        event_pulse
);
    reg pin_last_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            pin_last_reg <= 1'b0;
            event_pulse  <= 1'b0;
        end else begin
            pin_last_reg <= pin_sync;
            case (edge_sel)
                `EDGE_RISING:  event_pulse <= armed & pin_sync & ~pin_last_reg;
                `EDGE_FALLING: event_pulse <= armed & ~pin_sync & pin_last_reg;
                `EDGE_BOTH:    event_pulse <= armed & (pin_sync ^ pin_last_reg);
                // Reserved encoding detects nothing.
                default:       event_pulse <= 1'b0;
            endcase
        end
    end
endmodule // edge_select

// [design/half_mode_decode.v]
// Effective mode and run decode for one timer half.
`timescale 1ns/10ps
`include "timer_mode_defs.vh"

module half_mode_decode (
    input  wire       split,
    input  wire       enable,
    input  wire       freeze,
    input  wire       debug_halt,
    input  wire [1:0] mode_sel,
    output wire       run,
    output wire       capture_armed,
    output wire       one_shot,
    output wire       periodic
);
    // Freeze applies only during a debug halt.
    wire stalled = freeze & debug_halt;

    // Reserved mode 0 leaves the half idle even when enabled.
    assign one_shot      = enable & (mode_sel == `MODE_ONE_SHOT);
    assign periodic      = enable & (mode_sel == `MODE_PERIODIC);
    assign capture_armed = enable & split & (mode_sel == `MODE_CAPTURE);
    assign run           = (one_shot | periodic) & ~stalled;
endmodule // half_mode_decode

// [design/dual_timer_mode_control.v]
// APB register block and mode control for a dual-half general-purpose timer.
// Notes on behaviour
// - Config 0 concat32, 1 clock32, 4-7 split16.
// - Capture kind bit: 0 count, 1 time.
// - Half B mode: 1 one-shot, 2 periodic, 3 capture.
// - Mode fields interpreted per width config.
// - Split mode: half B mode independent.
// - 32-bit mode: B mode ignored, A used.
// - Half B edge: 0 rise, 1 fall, 3 both.
// - Bit 9 freezes half B during halt.
// - Running processor ignores both freeze bits.
// - Bit 8 enables half B.
// - Bit 6 inverts half A PWM output.
// - Bit 5 enables half A converter trigger.
// - Bit 4 enables clock counting.
// - Half A edge: 0 rise, 1 fall, 3 both.
// - Bit 1 freezes half A during halt.
// - Bit 0 enables half A.
// - Bit 7 reserved, read-only zero.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "timer_mode_defs.vh"

module dual_timer_mode_control (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        debug_halt,
    input  wire        half_a_pin,
    input  wire        half_b_pin,
    input  wire        half_a_pwm_raw,
    input  wire        half_a_timeout,
    output reg         half_a_pwm_out,
    output reg         half_a_adc_trigger,
    output reg         half_a_run,
    output reg         half_b_run,
    output reg         clock_run,
    output reg  [1:0]  half_a_mode_eff,
    output reg  [1:0]  half_b_mode_eff,
    output reg         half_a_capture_time,
    output reg         half_b_capture_time,
    output wire        half_a_capture_event,
    output wire        half_b_capture_event
);
    // ======================================================================
    // Register storage
    reg [2:0]  width_config_reg;
    reg [3:0]  half_a_mode_reg;
    reg [3:0]  half_b_mode_reg;
    reg [31:0] timer_control_reg;

    wire split    = width_config_reg[`CFG_SPLIT_BIT];
    wire concat32 = (width_config_reg == `CFG_CONCAT32);
    wire clock32  = (width_config_reg == `CFG_CLOCK32);

    wire access   = psel & penable;
    wire wr_taken = access & pwrite;
    wire mapped   = (paddr == `OFS_WIDTH_CONFIG) | (paddr == `OFS_HALF_A_MODE) |
                    (paddr == `OFS_HALF_B_MODE) | (paddr == `OFS_TIMER_CONTROL) |
                    (paddr == `OFS_TIMER_STATUS);

    // Zero wait states keep the bus simple; every access completes in one access cycle.
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    always @(posedge clock) begin
        if (!rst_n) begin
            width_config_reg  <= 3'h0;
            half_a_mode_reg   <= 4'h0;
            half_b_mode_reg   <= 4'h0;
            timer_control_reg <= 32'h0000_0000;
        end else if (wr_taken) begin
            case (paddr)
                `OFS_WIDTH_CONFIG:  width_config_reg  <= pwdata[2:0];
                `OFS_HALF_A_MODE:   half_a_mode_reg   <= pwdata[3:0];
                `OFS_HALF_B_MODE:   half_b_mode_reg   <= pwdata[3:0];
                `OFS_TIMER_CONTROL: timer_control_reg <= pwdata & `CTL_WRITE_MASK;
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Read path
    wire [31:0] status_word = {26'h0, half_b_capture_event, half_a_capture_event,
                               clock_run, half_b_run, half_a_run, split};

    always @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `OFS_WIDTH_CONFIG:  prdata <= {29'h0, width_config_reg};
                `OFS_HALF_A_MODE:   prdata <= {28'h0, half_a_mode_reg};
                `OFS_HALF_B_MODE:   prdata <= {28'h0, half_b_mode_reg};
                `OFS_TIMER_CONTROL: prdata <= timer_control_reg;
                `OFS_TIMER_STATUS:  prdata <= status_word;
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================================
    // Configuration decode

    // In 32-bit timer mode half B follows half A's mode register entirely.
    wire [3:0] b_mode_src = split ? half_b_mode_reg : half_a_mode_reg;

    wire a_en   = timer_control_reg[`CTL_A_ENABLE];
    wire b_en   = timer_control_reg[`CTL_B_ENABLE];
    wire a_frz  = timer_control_reg[`CTL_A_FREEZE];
    wire b_frz  = timer_control_reg[`CTL_B_FREEZE];
    wire [1:0] a_edge = timer_control_reg[`CTL_A_EDGE_MSB:`CTL_A_EDGE_LSB];
    wire [1:0] b_edge = timer_control_reg[`CTL_B_EDGE_MSB:`CTL_B_EDGE_LSB];

    // ======================================================================
    // Input synchronisers
    reg [1:0] halt_sync_reg;
    reg [1:0] a_pin_sync_reg;
    reg [1:0] b_pin_sync_reg;

    always @(posedge clock) begin
        if (!rst_n) begin
            halt_sync_reg  <= 2'b00;
            a_pin_sync_reg <= 2'b00;
            b_pin_sync_reg <= 2'b00;
        end else begin
            halt_sync_reg  <= {halt_sync_reg[0], debug_halt};
            a_pin_sync_reg <= {a_pin_sync_reg[0], half_a_pin};
            b_pin_sync_reg <= {b_pin_sync_reg[0], half_b_pin};
        end
    end

    wire halted = halt_sync_reg[1];

    // ======================================================================
    // Per-half decode
    wire a_run_next;
    wire a_cap_armed;
    wire b_run_next;
    wire b_cap_armed;

    half_mode_decode u_half_a (
        .split         (split),
        // Half A counts on its own only in the concatenated or split layouts; reserved layouts leave it idle.
        .enable        (a_en & (concat32 | split)),
        .freeze        (a_frz),
        .debug_halt    (halted),
        .mode_sel      (half_a_mode_reg[`MODE_SEL_MSB:`MODE_SEL_LSB]),
        .run           (a_run_next),
        .capture_armed (a_cap_armed),
        .one_shot      (),
        .periodic      ()
    );

    // Half B only exists as its own timer in split mode.
    half_mode_decode u_half_b (
        .split         (split),
        .enable        (b_en & split),
        .freeze        (b_frz),
        .debug_halt    (halted),
        .mode_sel      (b_mode_src[`MODE_SEL_MSB:`MODE_SEL_LSB]),
        .run           (b_run_next),
        .capture_armed (b_cap_armed),
        .one_shot      (),
        .periodic      ()
    );

    edge_select u_edge_a (
        .clock       (clock),
        .rst_n       (rst_n),
        .pin_sync    (a_pin_sync_reg[1]),
        .edge_sel    (a_edge),
        .armed       (a_cap_armed),
        .event_pulse (half_a_capture_event)
    );

    edge_select u_edge_b (
        .clock       (clock),
        .rst_n       (rst_n),
        .pin_sync    (b_pin_sync_reg[1]),
        .edge_sel    (b_edge),
        .armed       (b_cap_armed),
        .event_pulse (half_b_capture_event)
    );

    // ======================================================================
    // Registered outputs
    always @(posedge clock) begin
        if (!rst_n) begin
            half_a_pwm_out      <= 1'b0;
            half_a_adc_trigger  <= 1'b0;
            half_a_run          <= 1'b0;
            half_b_run          <= 1'b0;
            clock_run           <= 1'b0;
            half_a_mode_eff     <= 2'h0;
            half_b_mode_eff     <= 2'h0;
            half_a_capture_time <= 1'b0;
            half_b_capture_time <= 1'b0;
        end else begin
            half_a_pwm_out      <= half_a_pwm_raw ^ timer_control_reg[`CTL_A_PWM_INV];
            half_a_adc_trigger  <= half_a_timeout & timer_control_reg[`CTL_A_ADC_TRIG];
            // The counting halves also need a one-shot or periodic mode; a reserved mode stays idle.
            half_a_run          <= a_run_next;
            half_b_run          <= b_run_next;
            // Clock counting is only meaningful in the 32-bit clock configuration.
            clock_run           <= clock32 & timer_control_reg[`CTL_CLOCK_EN] &
                                   a_en & ~(a_frz & halted);
            half_a_mode_eff     <= half_a_mode_reg[`MODE_SEL_MSB:`MODE_SEL_LSB];
            half_b_mode_eff     <= b_mode_src[`MODE_SEL_MSB:`MODE_SEL_LSB];
            half_a_capture_time <= half_a_mode_reg[`MODE_CAPKIND_BIT];
            half_b_capture_time <= b_mode_src[`MODE_CAPKIND_BIT];
        end
    end
endmodule // dual_timer_mode_control

// [bench/dual_timer_mode_control_monitor.sv]
// Assertion checker for the dual timer mode control block.
`timescale 1ns/10ps
module dual_timer_mode_control_monitor (
    input wire        clock,
    input wire        rst_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        debug_halt,
    input wire        half_a_pin,
    input wire        half_b_pin,
    input wire        half_a_pwm_raw,
    input wire        half_a_timeout,
    input wire        half_a_pwm_out,
    input wire        half_a_adc_trigger,
    input wire        half_a_run,
    input wire        half_b_run,
    input wire        clock_run,
    input wire [1:0]  half_a_mode_eff,
    input wire [1:0]  half_b_mode_eff,
    input wire        half_a_capture_time,
    input wire        half_b_capture_time,
    input wire        half_a_capture_event,
    input wire        half_b_capture_event
);
// ========
// Shadow of the written fields, so each output can be tied to its cause.
reg  [11:0] ctl_reg;
reg  [2:0]  cfg_reg;
wire        wr = psel && penable && pwrite;
always @(posedge clock) begin
    if (!rst_n) begin
        ctl_reg <= 12'h000;
        cfg_reg <= 3'h0;
    end else begin
        if (wr && paddr == 12'h00C) ctl_reg <= pwdata[11:0] & 12'hF7F;
        if (wr && paddr == 12'h000) cfg_reg <= pwdata[2:0];
    end
end
// ========
// Properties. Freeze checks allow for the two-flop halt synchroniser.
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no slave error");
a_reserved_zero: assert property (psel && penable && !pwrite && paddr == 12'h00C
    |-> prdata[31:12] == 20'h0 && !prdata[7]) else $error("reserved bits set");
a_pwm_invert: assert property (1 |=> half_a_pwm_out == $past(half_a_pwm_raw ^ ctl_reg[6])) else $error("pwm");
a_trigger_gate: assert property (half_a_adc_trigger == $past(half_a_timeout && ctl_reg[5])) else $error("trig");
a_b_concat_idle: assert property (!cfg_reg[2] |=> !half_b_run) else $error("b runs unsplit");
a_b_mirror: assert property (cfg_reg == 3'h0 |=> half_b_mode_eff == half_a_mode_eff) else $error("b mode");
a_a_disabled: assert property (!ctl_reg[0] |=> !half_a_run) else $error("a runs disabled");
a_clock_gate: assert property (!ctl_reg[4] |=> !clock_run) else $error("clock runs disabled");
a_a_freeze: assert property ((debug_halt && ctl_reg[1]) [*5] |-> !half_a_run) else $error("a not frozen");
a_b_freeze: assert property ((debug_halt && ctl_reg[9]) [*5] |-> !half_b_run) else $error("b not frozen");
a_run_normal: assert property ((!debug_halt && ctl_reg[0] && cfg_reg[2] && half_a_mode_eff == 2'h2) [*5]
    |-> half_a_run) else $error("a stalled");
cover property (half_b_capture_event);
cover property (half_a_adc_trigger);
cover property (debug_halt && ctl_reg[9] && ctl_reg[8]);
endmodule // dual_timer_mode_control_monitor
bind dual_timer_mode_control dual_timer_mode_control_monitor u_mon (.*);

// [bench/dual_timer_mode_control_bench.sv]
// Self-checking bench for the dual timer mode control block.
`timescale 1ns/10ps
module dual_timer_mode_control_bench;
// ========
// Signals, design and helpers
reg         clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ev;
reg  [11:0] paddr = 0;
reg  [31:0] pwdata = 0, rv;
reg         debug_halt = 0, half_a_pin = 0, half_b_pin = 0, half_a_pwm_raw = 0, half_a_timeout = 0;
wire        pready, pslverr, half_a_pwm_out, half_a_adc_trigger, half_a_run, half_b_run, clock_run;
wire        half_a_capture_time, half_b_capture_time, half_a_capture_event, half_b_capture_event;
wire [31:0] prdata;
wire [1:0]  half_a_mode_eff, half_b_mode_eff;
integer     n_errors = 0, num_checks = 0, nc = 0, nt = 0, b0, i, e;
reg  [43:0] rows [0:5] = '{{12'h000, 32'h7}, {12'h004, 32'hF}, {12'h008, 32'hF}, {12'h00C, 32'hF7F},
                           {12'h010, 32'h1}, {12'h014, 32'h0}};
dual_timer_mode_control dut (.*);
always #5 clock = ~clock;
always @(posedge clock) begin
    nc <= nc + (half_a_capture_event === 1'b1) + (half_b_capture_event === 1'b1);
    nt <= nt + (half_a_adc_trigger === 1'b1);
end
task chk(input string nm, input [31:0] exp, input [31:0] got);
    num_checks++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
endtask
// The request is held until pready is seen high; one idle cycle follows.
task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task settle(input integer n);
    repeat (n) @(negedge clock);
endtask
task tally_and_finish;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
initial begin
    repeat (4000) @(posedge clock);
    n_errors++;
    tally_and_finish;
end
// ========
// Sequence
initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    for (i = 0; i < 6; i++) begin
        apb(rows[i][43:32], 1, 32'hFFFFFFFF);
        chk("slverr", rows[i][43:32] == 12'h014, ev);
        apb(rows[i][43:32], 0, 0);
        chk("readback", rows[i][31:0], rv);
    end
    @(posedge clock);
    rst_n <= 0;
    @(posedge clock);
    rst_n <= 1;
    for (i = 0; i < 4; i++) begin
        apb(12'(4 * i), 0, 0);
        chk("reset", 0, rv);
    end
    chk("reset_run", 0, {half_a_run, half_b_run, clock_run});
    apb(12'h000, 1, 4);
    for (i = 1; i < 4; i++) begin
        apb(12'h008, 1, 4 + i);
        apb(12'h004, 1, 4 - i);
        settle(2);
        chk("b_mode", i, half_b_mode_eff);
        chk("a_mode", 4 - i, half_a_mode_eff);
        chk("capture_kind", 2, {half_b_capture_time, half_a_capture_time});
    end
    // Half A must sit in capture mode, or its edges are never armed.
    apb(12'h004, 1, 3);
    // Edge 0x2 is reserved; this design counts no edges there.
    for (e = 0; e < 4; e++) begin
        apb(12'h00C, 1, (e << 10) | (e << 2) | 32'h101);
        for (i = 1; i >= 0; i--) begin
            b0 = nc;
            @(posedge clock);
            half_a_pin <= i;
            half_b_pin <= i;
            settle(6);
            chk("edges", (e == 3 || e == !i) ? 2 : 0, nc - b0);
        end
    end
    apb(12'h004, 1, 2);
    apb(12'h008, 1, 2);
    for (i = 3; i >= 0; i--) begin
        apb(12'h00C, 1, i[1] ? 32'h303 : 32'h101);
        @(posedge clock);
        debug_halt <= i[0];
        settle(6);
        chk("halt_run", (i == 3) ? 0 : 3, {half_a_run, half_b_run});
    end
    for (i = 0; i < 4; i++) begin
        apb(12'h00C, 1, i[1] ? 32'h60 : 32'h0);
        b0 = nt;
        @(posedge clock);
        half_a_pwm_raw <= i[0];
        half_a_timeout <= 1;
        @(posedge clock);
        half_a_timeout <= 0;
        settle(3);
        chk("pwm", i[0] ^ i[1], half_a_pwm_out);
        chk("trigger", i[1], nt - b0);
    end
    apb(12'h000, 1, 0);
    apb(12'h004, 1, 2);
    apb(12'h008, 1, 1);
    apb(12'h00C, 1, 32'h101);
    settle(3);
    chk("mirror", 2, half_b_mode_eff);
    chk("concat_run", 2, {half_a_run, half_b_run});
    apb(12'h000, 1, 1);
    for (i = 1; i >= 0; i--) begin
        apb(12'h00C, 1, (i << 4) | 1);
        settle(3);
        chk("clock_run", i, clock_run);
    end
    tally_and_finish;
end
endmodule // dual_timer_mode_control_bench
